// *** hw/dsc_pkg.sv ***
// Constants, register map and types for the speed command selector.
// Assumes a 32-bit classic Wishbone slave port and a 20 MHz clock.
package dsc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_JOG_FREQ = 8'h04;
    localparam logic [7:0] ADR_JOG_TIME = 8'h08;
    localparam logic [7:0] ADR_REF_FREQ = 8'h0c;
    localparam logic [7:0] ADR_BASE_FREQ = 8'h10;
    localparam logic [7:0] ADR_TERM_MAP = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_OUT_FREQ = 8'h1c;
    localparam logic [7:0] ADR_PRESET0 = 8'h40;
    localparam logic [7:0] ADR_PRESET_LAST = 8'h78;
    // Control field positions
    localparam int CTRL_OPMODE_LSB = 0;
    localparam int CTRL_REMOTE_LSB = 4;
    localparam int CTRL_PATTERN_LSB = 8;
    localparam int CTRL_INCR_BIT = 12;
    // Reset values, frequencies in 0.1 Hz, times in selected steps
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] JOG_FREQ_RST = 16'h0032;
    localparam logic [15:0] JOG_TIME_RST = 16'h0005;
    localparam logic [15:0] REF_FREQ_RST = 16'h0258;
    localparam logic [15:0] BASE_FREQ_RST = 16'h0258;
    localparam logic [27:0] TERM_MAP_RST = 28'hfff_f210;
    localparam logic [15:0] PRESET_HIGH_RST = 16'h0258;
    localparam logic [15:0] PRESET_MID_RST = 16'h012c;
    localparam logic [15:0] PRESET_LOW_RST = 16'h0064;
    localparam logic [15:0] FREQ_MAX = 16'h0fa0;
    localparam logic [15:0] NOT_SEL = 16'h270f;
    localparam logic [15:0] TIME_MAX = 16'h8ca0;
    // Terminal function codes
    localparam logic [3:0] FN_LOW = 4'h0;
    localparam logic [3:0] FN_MID = 4'h1;
    localparam logic [3:0] FN_HIGH = 4'h2;
    localparam logic [3:0] FN_SECOND = 4'h3;
    localparam logic [3:0] FN_JOG = 4'h5;
    localparam logic [3:0] FN_EXT = 4'h8;
    // Operation modes, remote selections, ramp pattern
    localparam logic [2:0] OPM_SWITCH = 3'h0;
    localparam logic [2:0] OPM_PANEL = 3'h1;
    localparam logic [2:0] OPM_EXT = 3'h2;
    localparam logic [2:0] OPM_COMB3 = 3'h3;
    localparam logic [2:0] OPM_COMB4 = 3'h4;
    localparam logic [1:0] REM_OFF = 2'h0;
    localparam logic [1:0] REM_STORE = 2'h1;
    localparam logic [1:0] REM_CLR_STOP = 2'h3;
    localparam logic [1:0] PAT_SCURVE_A = 2'h1;
    localparam int N_TERM = 7;
    localparam int N_PRESET = 15;
    // Speed number for {ext, high, mid, low}; speed k sits at preset k-1
    localparam logic [3:0] COMBO_SPEED [0:15] = '{4'h0, 4'h3, 4'h2, 4'h4,
        4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he,
        4'hf};
    typedef enum logic [2:0] {SRC_NONE, SRC_JOG, SRC_MULTI, SRC_ANALOG4,
        SRC_ANALOG2, SRC_REMOTE} dsc_src_type;
endpackage : dsc_pkg

// *** hw/dsc_select.sv ***
// Speed command selector: multi-speed, jog and remote-setting inputs.
// Assumes synchronous inputs on clk and a classic Wishbone master.
//
// Operation
// [RL1] One basic input alone selects high, middle or low preset.
// [RL2] Several basic inputs together: lowest-ranked input's preset wins.
// [RL3] High plus middle selects the middle preset.
// [RL4] Function codes 0,1,2 map low, middle, high onto any terminal.
// [RL5] Speeds 4 to 15 decode high, middle, low and extension inputs.
// [RL6] Presets 4 to 15 reset to 9999 and count as not selected.
// [RL7] Function code 8 maps the extension input onto a terminal.
// [RL8] Speed 8 unset, extension alone: run at the low preset.
// [RL9] Priority: jog, multi-speed, analog 4, analog 2.
// [RL10] Multi-speed works only in external or combined modes 3, 4.
// [RL11] Nonzero remote selection disables multi-speed selection.
// [RL12] Remote 1 to 3: high raises, middle lowers, low clears.
// [RL13] Only remote selection 1 stores the set frequency in memory.
// [RL14] Remote 3 clears the setting when both starts go inactive.
// [RL15] Jog frequency 0 to 400 Hz, default 5 Hz.
// [RL16] One jog ramp time, default 0.5 s, to reference frequency.
// [RL17] Increment 0: 0.1 s steps; increment 1: 0.01 s steps.
// [RL18] With jog input on, start inputs run the motor at jog speed.
// [RL19] Function code 5 maps the jog input onto a terminal.
// [RL20] Panel jog runs only while the start key is held.
// [RL21] S-curve A pattern measures jog ramp to base frequency.
// [RL22] Second-function input never picks second ramps during jog.
// [RL23] Mode 4: panel run/fwd/rev keys start jog, stop key stops.
// [RL24] Mode 3 disables jog entirely.
// [RL25] Presets may be rewritten at any time, in any mode.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module dsc_select
    import dsc_pkg::*;
(
    input wire logic clk, // 20 MHz control clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lane selects
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic [dsc_pkg::N_TERM-1:0] term_in, // Input terminals
    input wire logic forward_start, // Forward start input
    input wire logic reverse_start, // Reverse start input
    input wire logic panel_select, // Panel chosen when mode is 0
    input wire logic panel_jog_mode, // Panel is in jog mode
    input wire logic panel_run_key, // Panel run key held
    input wire logic panel_fwd_key, // Handheld forward key held
    input wire logic panel_rev_key, // Handheld reverse key held
    input wire logic panel_stop_key, // Stop/reset key held
    input wire logic analog4_valid, // Terminal 4 command present
    input wire logic [15:0] analog4_freq, // Terminal 4 frequency
    input wire logic analog2_valid, // Terminal 2 command present
    input wire logic [15:0] analog2_freq, // Terminal 2 frequency
    output logic [15:0] freq_cmd, // Selected frequency, 0.1 Hz
    output dsc_pkg::dsc_src_type freq_source, // Source of freq_cmd
    output logic run_fwd, // Run forward request
    output logic run_rev, // Run reverse request
    output logic [15:0] ramp_time, // Jog ramp time in steps
    output logic ramp_fine, // Ramp steps are 0.01 s
    output logic [15:0] ramp_ref_freq, // Ramp measured to this
    output logic second_ramp, // Use second ramp times
    output logic second_func, // Other second functions on
    output logic remote_raise, // Remote frequency raise
    output logic remote_lower, // Remote frequency lower
    output logic remote_clear, // Remote setting clear
    output logic remote_store_en, // Keep setting over power cycle
    output logic remote_clear_stop // Clear pulse on start release
);
    import dsc_pkg::*;

    logic [31:0] ctrl;
    logic [15:0] jog_freq;
    logic [15:0] jog_time;
    logic [15:0] ref_freq;
    logic [15:0] base_freq;
    logic [27:0] term_map;
    logic [15:0] preset [0:N_PRESET-1];
    logic jog_latch;
    logic jog_latch_rev;
    logic start_any_q;

    // Control fields
    logic [2:0] op_mode;
    logic [1:0] remote_sel;
    logic [1:0] pattern;
    assign op_mode = ctrl[CTRL_OPMODE_LSB +: 3];
    assign remote_sel = ctrl[CTRL_REMOTE_LSB +: 2];
    assign pattern = ctrl[CTRL_PATTERN_LSB +: 2];

    // Terminal function decode
    logic sig_low, sig_mid, sig_high, sig_ext, sig_jog, sig_second;
    always_comb begin
        sig_low = 1'b0;
        sig_mid = 1'b0;
        sig_high = 1'b0;
        sig_ext = 1'b0;
        sig_jog = 1'b0;
        sig_second = 1'b0;
        for (int t = 0; t < N_TERM; t++) begin
            if (term_in[t]) begin
                sig_low |= term_map[4*t +: 4] == FN_LOW; // RL4
                sig_mid |= term_map[4*t +: 4] == FN_MID; // RL4
                sig_high |= term_map[4*t +: 4] == FN_HIGH; // RL4
                sig_ext |= term_map[4*t +: 4] == FN_EXT; // RL7
                sig_jog |= term_map[4*t +: 4] == FN_JOG; // RL19
                sig_second |= term_map[4*t +: 4] == FN_SECOND;
            end
        end
    end

    // Operation mode qualifiers
    logic mode_panel, mode_extern, multi_ok, start_any;
    assign mode_panel = op_mode == OPM_PANEL
        || (op_mode == OPM_SWITCH && panel_select);
    assign mode_extern = op_mode == OPM_EXT
        || (op_mode == OPM_SWITCH && !panel_select);
    assign multi_ok = (mode_extern || op_mode == OPM_COMB3
        || op_mode == OPM_COMB4) && remote_sel == REM_OFF; // RL10 RL11
    assign start_any = forward_start || reverse_start;

    // Jog requests from terminals, panel keys and mode 4
    logic jog_ext, jog_panel, jog_active, panel_keys;
    assign panel_keys = panel_run_key || panel_fwd_key || panel_rev_key;
    assign jog_ext = sig_jog && mode_extern && start_any; // RL18
    assign jog_panel = mode_panel && panel_jog_mode && panel_keys; // RL20
    assign jog_active = op_mode != OPM_COMB3 // RL24
        && (jog_ext || jog_panel || jog_latch);

    // Mode 4 jog start by panel keys, held until stop key or jog off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            jog_latch <= 1'b0;
            jog_latch_rev <= 1'b0;
        end else if (op_mode != OPM_COMB4 || !sig_jog || panel_stop_key) begin
            jog_latch <= 1'b0; // RL23
        end else if (panel_keys) begin
            jog_latch <= 1'b1; // RL23
            jog_latch_rev <= panel_rev_key;
        end
    end

    // Multi-speed decode with fallback to lower-signal priority
    logic [3:0] speed;
    logic multi_hit;
    logic [15:0] multi_freq;
    always_comb begin
        speed = COMBO_SPEED[{sig_ext, sig_high, sig_mid, sig_low}]; // RL5
        multi_hit = speed != 4'h0;
        multi_freq = 16'h0000;
        if (speed >= 4'h4 && preset[speed - 4'h1] != NOT_SEL) begin
            multi_freq = preset[speed - 4'h1]; // RL5 RL6
        end else if (sig_low) begin
            multi_freq = preset[2]; // RL1 RL2
        end else if (sig_mid) begin
            multi_freq = preset[1]; // RL2 RL3
        end else if (sig_high) begin
            multi_freq = preset[0]; // RL1
        end else begin
            multi_freq = preset[2]; // RL8
        end
    end

    // Source priority and next output values
    dsc_src_type next_source;
    logic [15:0] next_freq;
    always_comb begin
        next_source = SRC_NONE;
        next_freq = 16'h0000;
        if (jog_active) begin // RL9
            next_source = SRC_JOG;
            next_freq = jog_freq;
        end else if (multi_ok && multi_hit) begin
            next_source = SRC_MULTI;
            next_freq = multi_freq;
        end else if (remote_sel != REM_OFF) begin
            next_source = SRC_REMOTE;
        end else if (analog4_valid) begin
            next_source = SRC_ANALOG4;
            next_freq = analog4_freq;
        end else if (analog2_valid) begin
            next_source = SRC_ANALOG2;
            next_freq = analog2_freq;
        end
    end

    // Frequency command and direction outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            freq_cmd <= 16'h0000;
            freq_source <= SRC_NONE;
            run_fwd <= 1'b0;
            run_rev <= 1'b0;
        end else begin
            freq_cmd <= next_freq;
            freq_source <= next_source;
            if (jog_latch) begin
                run_fwd <= !jog_latch_rev;
                run_rev <= jog_latch_rev;
            end else if (jog_panel && op_mode != OPM_COMB3) begin
                run_fwd <= !panel_rev_key; // RL20
                run_rev <= panel_rev_key;
            end else begin
                run_fwd <= forward_start; // RL18
                run_rev <= reverse_start && !forward_start;
            end
        end
    end

    // Ramp selection for jog
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ramp_time <= JOG_TIME_RST;
            ramp_fine <= 1'b0;
            ramp_ref_freq <= REF_FREQ_RST;
            second_ramp <= 1'b0;
            second_func <= 1'b0;
        end else begin
            ramp_time <= jog_time; // RL16
            ramp_fine <= ctrl[CTRL_INCR_BIT]; // RL17
            ramp_ref_freq <= pattern == PAT_SCURVE_A ? base_freq
                : ref_freq; // RL21
            second_ramp <= sig_second && !jog_active; // RL22
            second_func <= sig_second; // RL22
        end
    end

    // Remote setting controls; raise, lower and clear idle during jog
    always_ff @(posedge clk) begin
        if (!nrst) begin
            remote_raise <= 1'b0;
            remote_lower <= 1'b0;
            remote_clear <= 1'b0;
            remote_store_en <= 1'b0;
            remote_clear_stop <= 1'b0;
            start_any_q <= 1'b0;
        end else begin
            start_any_q <= start_any;
            remote_raise <= remote_sel != REM_OFF && !jog_active
                && sig_high; // RL12
            remote_lower <= remote_sel != REM_OFF && !jog_active
                && sig_mid; // RL12
            remote_clear <= remote_sel != REM_OFF && !jog_active
                && sig_low; // RL12
            remote_store_en <= remote_sel == REM_STORE; // RL13
            remote_clear_stop <= remote_sel == REM_CLR_STOP
                && start_any_q && !start_any; // RL14
        end
    end

    // Wishbone decode
    logic wb_req, wr_en;
    logic [31:0] wmask;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = wb_req && wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Merge selected byte lanes into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] m, input logic [31:0] d);
        merge = (old & ~m) | (d & m);
    endfunction : merge

    // Clamp a written frequency; 9999 kept only where allowed
    function automatic logic [15:0] clampf(input logic [15:0] v,
        input logic allow_ns);
        if (allow_ns && v == NOT_SEL) begin
            clampf = v;
        end else if (v > FREQ_MAX) begin
            clampf = FREQ_MAX;
        end else begin
            clampf = v;
        end
    endfunction : clampf

    // Each register merged with the written byte lanes
    logic [31:0] jf_w, jt_w, rf_w, bf_w, tm_w, pr_w;
    assign jf_w = merge({16'h0000, jog_freq}, wmask, wb_dat_i);
    assign jt_w = merge({16'h0000, jog_time}, wmask, wb_dat_i);
    assign rf_w = merge({16'h0000, ref_freq}, wmask, wb_dat_i);
    assign bf_w = merge({16'h0000, base_freq}, wmask, wb_dat_i);
    assign tm_w = merge({4'h0, term_map}, wmask, wb_dat_i);
    assign pr_w = merge({16'h0000, preset[wb_adr_i[5:2]]}, wmask, wb_dat_i);

    // Configuration registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl <= CTRL_RST;
            jog_freq <= JOG_FREQ_RST; // RL15
            jog_time <= JOG_TIME_RST; // RL16
            ref_freq <= REF_FREQ_RST; // RL16
            base_freq <= BASE_FREQ_RST;
            term_map <= TERM_MAP_RST; // RL4
        end else if (wr_en) begin
            case (wb_adr_i)
                ADR_CTRL: ctrl <= merge(ctrl, wmask, wb_dat_i) & 32'h0000_1337;
                ADR_JOG_FREQ: jog_freq <= clampf(jf_w[15:0], 1'b0); // RL15
                ADR_JOG_TIME: jog_time <= jt_w[15:0] > TIME_MAX ? TIME_MAX
                    : jt_w[15:0]; // RL17
                ADR_REF_FREQ: ref_freq <= clampf(rf_w[15:0], 1'b0);
                ADR_BASE_FREQ: base_freq <= clampf(bf_w[15:0], 1'b0);
                ADR_TERM_MAP: term_map <= tm_w[27:0];
                default: ;
            endcase
        end
    end

    // Preset table, writable at any time
    always_ff @(posedge clk) begin
        if (!nrst) begin
            preset[0] <= PRESET_HIGH_RST;
            preset[1] <= PRESET_MID_RST;
            preset[2] <= PRESET_LOW_RST;
            for (int i = 3; i < N_PRESET; i++) begin
                preset[i] <= NOT_SEL; // RL6
            end
        end else if (wr_en && wb_adr_i >= ADR_PRESET0
            && wb_adr_i <= ADR_PRESET_LAST && wb_adr_i[1:0] == 2'h0) begin
            preset[wb_adr_i[5:2]] <= clampf(pr_w[15:0],
                wb_adr_i[5:2] >= 4'h3); // RL25 RL6
        end
    end

    // Read data and one-cycle acknowledge; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    ADR_CTRL: wb_dat_o <= ctrl;
                    ADR_JOG_FREQ: wb_dat_o <= {16'h0000, jog_freq};
                    ADR_JOG_TIME: wb_dat_o <= {16'h0000, jog_time};
                    ADR_REF_FREQ: wb_dat_o <= {16'h0000, ref_freq};
                    ADR_BASE_FREQ: wb_dat_o <= {16'h0000, base_freq};
                    ADR_TERM_MAP: wb_dat_o <= {4'h0, term_map};
                    ADR_STATUS: wb_dat_o <= {16'h0000, 5'h00, jog_active,
                        sig_second, sig_jog, sig_ext, sig_high, sig_mid,
                        sig_low, run_rev, freq_source};
                    ADR_OUT_FREQ: wb_dat_o <= {16'h0000, freq_cmd};
                    default: begin
                        if (wb_adr_i >= ADR_PRESET0
                            && wb_adr_i <= ADR_PRESET_LAST
                            && wb_adr_i[1:0] == 2'h0) begin
                            wb_dat_o <= {16'h0000, preset[wb_adr_i[5:2]]};
                        end
                    end
                endcase
            end
        end
    end

    // Checks on the selection and bus behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence bus_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence bus_ack_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_ack_once_a: assert property (bus_req_s |=> bus_ack_s)
        else $error("ack not a single pulse after request");
    jog_mode3_off_a: assert property (op_mode == OPM_COMB3 // RL24
        |=> freq_source != SRC_JOG)
        else $error("jog selected in mode 3");
    jog_first_a: assert property (jog_active |=> freq_source == SRC_JOG // RL9
        && freq_cmd == $past(jog_freq))
        else $error("jog not given priority");
    high_mid_pick_a: assert property (multi_ok && !jog_active && sig_high // RL3
        && sig_mid && !sig_low && !sig_ext && preset[5] == NOT_SEL
        |=> freq_cmd == $past(preset[1]))
        else $error("high and middle did not pick middle");
    ext_fallback_a: assert property (multi_ok && !jog_active && sig_ext // RL8
        && !sig_high && !sig_mid && !sig_low && preset[7] == NOT_SEL
        |=> freq_cmd == $past(preset[2]))
        else $error("extension alone did not fall back to low");
    remote_no_multi_a: assert property (remote_sel != REM_OFF // RL11
        |=> freq_source != SRC_MULTI)
        else $error("multi-speed active with remote setting");
    jog_no_second_a: assert property (sig_second && jog_active // RL22
        |=> !second_ramp && second_func)
        else $error("second ramp during jog");
    ramp_base_a: assert property (pattern == PAT_SCURVE_A // RL21
        |=> ramp_ref_freq == $past(base_freq))
        else $error("S-curve ramp not measured to base");
    clear_on_stop_a: assert property (remote_sel == REM_CLR_STOP // RL14
        && start_any_q && !start_any |=> remote_clear_stop)
        else $error("remote clear missing on start release");
endmodule : dsc_select

// *** sim/dsc_contacts.sv ***
// Partner model: external contacts on the drive's input terminals.
// Assumes the bench sets wanted levels; contacts move after each edge.
`timescale 1ns/10ps
module dsc_contacts (
    input wire logic clk, // Drive clock
    input wire logic [6:0] want_term, // Wanted terminal levels
    input wire logic want_fwd, // Wanted forward start
    input wire logic want_rev, // Wanted reverse start
    output logic [6:0] term_in, // Terminal contacts
    output logic forward_start, // Forward start contact
    output logic reverse_start // Reverse start contact
);
    // Contacts close just after an edge and stay as levels
    always_ff @(posedge clk) begin
        term_in <= want_term;
        forward_start <= want_fwd;
        reverse_start <= want_rev;
    end
endmodule : dsc_contacts

// *** sim/drive_speed_command_select_tb.sv ***
// Self-checking bench for the speed command selector.
// Assumes dsc_pkg, dsc_select and the contact model; one 20 MHz clock.
`timescale 1ns/10ps
module drive_speed_command_select_tb;
    import dsc_pkg::*;
    logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ack, fwd_w = 0;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0, rdo, rd;
    logic [6:0] term_w = '0, term;
    logic [5:0] pnl = '0;
    logic a4v = 0, a2v = 0, fwd, rev, run_f, run_r, raise, store, fine;
    logic s_ramp, s_func, lower, clr, clr_stop;
    logic [15:0] a4f = '0, a2f = '0, fcmd, rtime, rref;
    dsc_src_type src;
    int fail_count = 0, n_compared = 0, clr_n = 0;
    dsc_contacts u_part (.clk(clk), .want_term(term_w), .want_fwd(fwd_w),
        .want_rev(1'b0), .term_in(term), .forward_start(fwd),
        .reverse_start(rev));
    dsc_select u_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack), .term_in(term),
        .forward_start(fwd), .reverse_start(rev), .panel_select(pnl[0]),
        .panel_jog_mode(pnl[1]), .panel_run_key(pnl[2]),
        .panel_fwd_key(pnl[3]), .panel_rev_key(pnl[4]),
        .panel_stop_key(pnl[5]), .analog4_valid(a4v), .analog4_freq(a4f),
        .analog2_valid(a2v), .analog2_freq(a2f), .freq_cmd(fcmd),
        .freq_source(src), .run_fwd(run_f), .run_rev(run_r),
        .ramp_time(rtime), .ramp_fine(fine), .ramp_ref_freq(rref),
        .second_ramp(s_ramp), .second_func(s_func),
        .remote_raise(raise), .remote_lower(lower), .remote_clear(clr),
        .remote_store_en(store), .remote_clear_stop(clr_stop));
    // Count clear pulses on start release
    always @(posedge clk) begin
        if (clr_stop === 1'b1) clr_n <= clr_n + 1;
    end
    // Clock at 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Classic single cycle, held until ack is sampled high
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    // Set contacts, then let them pass partner and selector
    task automatic pins(logic [6:0] t, logic f);
        @(posedge clk);
        term_w <= t;
        fwd_w <= f;
        repeat (4) @(posedge clk);
    endtask : pins
    task automatic t_reset();
        bus(0, ADR_JOG_FREQ, 0);
        check("jog freq", rd, 32'h32);
        bus(0, ADR_JOG_TIME, 0);
        check("jog time", rd, 32'h5);
        bus(0, ADR_PRESET0 + 8'h1c, 0);
        check("speed 8", rd, 32'h270f);
        bus(0, 8'h30, 0);
        check("unmapped", rd, 0);
        check("ramp ref", rref, 32'h258);
        check("ramp time", rtime, 32'h5);
        $display("reset test done");
    endtask : t_reset
    task automatic t_multi();
        bus(1, ADR_CTRL, 32'h2);
        pins(7'h1, 0);
        check("low", fcmd, 32'h64);
        pins(7'h2, 0);
        check("mid", fcmd, 32'h12c);
        pins(7'h4, 0);
        check("high", fcmd, 32'h258);
        check("src", src, SRC_MULTI);
        pins(7'h6, 0);
        check("high mid", fcmd, 32'h12c);
        pins(7'h3, 0);
        check("mid low", fcmd, 32'h64);
        pins(7'h7, 0);
        check("all three", fcmd, 32'h64);
        $display("multi-speed test done");
    endtask : t_multi
    task automatic t_ext();
        bus(1, ADR_TERM_MAP, 32'hff85210);
        pins(7'h10, 0);
        check("ext unset", fcmd, 32'h64);
        bus(1, ADR_PRESET0 + 8'h1c, 32'h7b);
        repeat (2) @(posedge clk);
        check("speed 8", fcmd, 32'h7b);
        bus(1, ADR_PRESET0 + 8'h20, 32'hfa);
        pins(7'h11, 0);
        check("speed 9", fcmd, 32'hfa);
        bus(1, ADR_TERM_MAP, 32'hf08521f);
        pins(7'h20, 0);
        check("moved low", fcmd, 32'h64);
        pins(7'h01, 0);
        check("freed term", src, SRC_NONE);
        bus(1, ADR_TERM_MAP, 32'hff85210);
        $display("extension and map test done");
    endtask : t_ext
    task automatic t_prio();
        a4v <= 1'b1;
        a4f <= 16'h309;
        pins(7'h4, 0);
        check("multi over a4", fcmd, 32'h258);
        pins(7'h0, 0);
        check("a4", fcmd, 32'h309);
        pins(7'hc, 1);
        check("jog freq", fcmd, 32'h32);
        check("jog src", src, SRC_JOG);
        check("jog run", run_f, 1);
        bus(1, ADR_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        check("mode 3", src, SRC_MULTI);
        bus(1, ADR_CTRL, 32'h1);
        pins(7'h4, 0);
        check("panel", src, SRC_ANALOG4);
        bus(1, ADR_CTRL, 32'h4);
        repeat (2) @(posedge clk);
        check("mode 4", fcmd, 32'h258);
        a4v <= 1'b0;
        $display("priority and mode test done");
    endtask : t_prio
    task automatic t_remote();
        bus(1, ADR_CTRL, 32'h12);
        repeat (2) @(posedge clk);
        check("remote src", src, SRC_REMOTE);
        check("raise", raise, 1);
        check("store", store, 1);
        bus(1, ADR_CTRL, 32'h22);
        repeat (2) @(posedge clk);
        check("no store", store, 0);
        bus(1, ADR_CTRL, 32'h32);
        pins(7'h3, 1);
        check("lower", lower, 1);
        check("clear", clr, 1);
        check("no raise", raise, 0);
        pins(7'h3, 0);
        check("clear on stop", clr_n, 1);
        $display("remote test done");
    endtask : t_remote
    task automatic t_jog();
        bus(1, ADR_CTRL, 32'h1101);
        bus(1, ADR_BASE_FREQ, 32'h1f4);
        pnl <= 6'h12;
        repeat (3) @(posedge clk);
        check("panel jog", fcmd, 32'h32);
        check("panel rev", run_r, 1);
        check("fine steps", fine, 1);
        check("base ref", rref, 32'h1f4);
        pnl <= 6'h02;
        repeat (3) @(posedge clk);
        check("key up", src, SRC_NONE);
        bus(1, ADR_TERM_MAP, 32'h3f85210);
        bus(1, ADR_CTRL, 32'h4);
        pins(7'h48, 0);
        pnl <= 6'h04;
        @(posedge clk);
        pnl <= 6'h00;
        repeat (3) @(posedge clk);
        check("mode 4 jog", src, SRC_JOG);
        check("latched run", run_f, 1);
        check("jog ramp", s_ramp, 0);
        check("second func", s_func, 1);
        pnl <= 6'h20;
        repeat (3) @(posedge clk);
        check("stop key", src, SRC_NONE);
        check("second ramp", s_ramp, 1);
        pnl <= 6'h00;
        $display("jog test done");
    endtask : t_jog
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_multi();
        t_ext();
        t_prio();
        t_remote();
        t_jog();
        complete_run();
    end
    // Watchdog
    initial begin
        #(50 * 20000);
        fail_count++;
        complete_run();
    end
endmodule : drive_speed_command_select_tb
